// ### logic/ddr_burst_tracker.sv
// burst, byte-mask and bank open/close tracking for the memory device
//
// Summary of operation
// - write-to-read gap counts from edge after last beat
// - seamless writes every burst_beats/2 clocks accepted
// - interrupted length is twice command spacing
// - burst-stop decode: select low, 0,1 high, 2,3 low
// - stopped length is twice cycles to stop
// - stop ends newest burst after its latency
// - per-lane mask blocks byte on that beat
// - close decode: select low, 0,1 high, 2 low, 3 high
// - all-banks flag or three-bit bank select
// - auto-close flag closes bank after burst
// - column command decode, bit 2 selects read
// - write auto-close starts two cycles after burst
`timescale 1ns/1ps
module ddr_burst_tracker
  import ddr_cmd_pkg::*;
#(
  parameter int WL_CYC = 1,   // write_delay_cycles
  parameter int RL_CYC = 3,   // read_delay_cycles
  parameter int DQ_W   = 16   // data width, eight bits per lane
) (
  input  wire logic              core_clk,         // clock
  input  wire logic              rst,              // sync reset, high
  input  wire logic              cs_n,             // chip select, low
  input  wire logic [CA_W-1:0]   ca_rise,          // command/address
  input  wire logic              auto_close_pin_falling, // auto-close
  input  wire logic [4:0]        burst_beats,      // 4, 8 or 16
  input  wire logic [DQ_W-1:0]   wr_data,          // write beat data
  input  wire logic [DQ_W/8-1:0] byte_mask,        // high blocks lane
  output logic [DQ_W-1:0]        array_wdata,      // data to array
  output logic [DQ_W/8-1:0]      array_we,         // per-lane enables
  output logic                   rd_beat,          // read beat active
  output logic [BANKS-1:0]       bank_open,        // open bank map
  output logic                   spacing_err       // violation seen
);
  localparam logic [CNT_W-1:0] WL = CNT_W'(WL_CYC);
  localparam logic [CNT_W-1:0] RL = CNT_W'(RL_CYC);
  localparam logic [CNT_W-1:0] RTP_EFF = (RTP_CYC > 8'h02) ? RTP_CYC : 8'h02;

  cmd_if c ();
  cmd_decode u_dec (
    .cs_n                   (cs_n),
    .ca_rise                (ca_rise),
    .auto_close_pin_falling (auto_close_pin_falling),
    .dec                    (c)
  );

  typedef struct packed {
    logic [CNT_W-1:0]             wr_age;     // cycles since write cmd
    logic [CNT_W-1:0]             wr_len;     // burst cycles (beats/2)
    logic                         wr_live;
    logic                         wr_ap;
    logic [BANK_W-1:0]            wr_bank;
    logic [CNT_W-1:0]             rd_age;
    logic [CNT_W-1:0]             rd_len;
    logic                         rd_live;
    logic                         rd_ap;
    logic [BANK_W-1:0]            rd_bank;
    logic                         newest_wr;  // stop targets this one
    logic                         stop_used;
    logic [CNT_W-1:0]             wtr_wait;   // cycles till read allowed
    logic [BANKS-1:0][CNT_W-1:0]  bk_cnt;     // close or guard counter
    logic [BANKS-1:0][CNT_W-1:0]  bk_ras;     // age since activate
    bank_st_t [BANKS-1:0]         bk_st;
    logic [DQ_W-1:0]              wdata;
    logic [DQ_W/8-1:0]            we;
    logic                         rbeat;
    logic                         err;
    logic [BANKS-1:0]             open;
  } state_t;

  state_t s_q, s_d;

  function automatic logic [BANKS-1:0] bank_hit(input logic all,
                                                input logic [BANK_W-1:0] b);
    bank_hit = all ? {BANKS{1'b1}} : (BANKS'(1) << b);
  endfunction : bank_hit

  logic [CNT_W-1:0] half;
  logic             wr_beat;
  logic             rd_act;
  logic [BANKS-1:0] close_hit;
  logic             wr_end, rd_end;
  assign half      = CNT_W'(burst_beats >> 1);
  // beats land WL cycles after the command, two per clock
  assign wr_beat   = s_q.wr_live && s_q.wr_age >= WL &&
                     s_q.wr_age < WL + s_q.wr_len;
  assign rd_act    = s_q.rd_live && s_q.rd_age >= RL &&
                     s_q.rd_age < RL + s_q.rd_len;
  assign close_hit = bank_hit(c.all_banks, c.bank);
  assign wr_end    = s_q.wr_live && s_q.wr_age == WL + s_q.wr_len;
  assign rd_end    = s_q.rd_live && s_q.rd_age == RL + s_q.rd_len;

  always_comb begin
    s_d = s_q;
    s_d.err   = 1'b0;
    s_d.rbeat = rd_act;
    s_d.we    = '0;
    s_d.wdata = wr_data;
    if (wr_beat) s_d.we = ~byte_mask;
    if (s_q.wtr_wait != '0) s_d.wtr_wait = s_q.wtr_wait - 1'b1;
    if (s_q.wr_live) s_d.wr_age = s_q.wr_age + 1'b1;
    if (s_q.rd_live) s_d.rd_age = s_q.rd_age + 1'b1;
    // write-to-read guard starts on the edge after the last beat
    if (wr_end) begin
      s_d.wr_live  = 1'b0;
      s_d.wtr_wait = WTR_CYC;
      if (s_q.wr_ap) begin
        s_d.bk_st[s_q.wr_bank]  = BANK_CLOSING;
        s_d.bk_cnt[s_q.wr_bank] = WR_AUTO_LAG + RPPB_CYC - 8'h01;
      end
    end
    if (rd_end) begin
      s_d.rd_live = 1'b0;
      if (s_q.rd_ap) begin
        s_d.bk_st[s_q.rd_bank]  = BANK_CLOSING;
        s_d.bk_cnt[s_q.rd_bank] = RTP_CYC + RPPB_CYC - 8'h01;
      end
    end
    for (int b = 0; b < BANKS; b++) begin
      if (s_q.bk_ras[b] != '1) s_d.bk_ras[b] = s_q.bk_ras[b] + 1'b1;
      if (s_q.bk_cnt[b] != '0) s_d.bk_cnt[b] = s_q.bk_cnt[b] - 1'b1;
      // idle on the edge the close time runs out, not one later
      if (s_q.bk_st[b] == BANK_CLOSING && s_q.bk_cnt[b] <= 8'h01)
        s_d.bk_st[b] = BANK_IDLE;
    end
    case (c.cmd)
      CMD_WRITE, CMD_READ: begin
        if (s_q.bk_st[c.bank] != BANK_OPEN) s_d.err = 1'b1;
        // a read inside the write burst itself is early as well
        if (c.cmd == CMD_READ && (s_q.wtr_wait != '0 || s_q.wr_live))
          s_d.err = 1'b1;
        // interrupting the live write shortens it to 2x spacing
        if (c.cmd == CMD_WRITE && wr_beat == 1'b0 && s_q.wr_live &&
            s_q.wr_age < s_q.wr_len)
          s_d.err = 1'b1;
        if (c.cmd == CMD_WRITE && s_q.wr_live &&
            s_q.wr_age < s_q.wr_len) begin
          if (burst_beats == BL4 || s_q.wr_ap || s_q.wr_age[0])
            s_d.err = 1'b1;
          // spacing of exactly half the burst is seamless
        end
        if (c.cmd == CMD_WRITE) begin
          if (s_q.wr_live && s_q.wr_age < s_q.wr_len)
            s_d.wr_len = s_q.wr_age;
          s_d.wr_live   = 1'b1;
          s_d.wr_age    = 8'h01;
          s_d.wr_len    = half;
          s_d.wr_ap     = c.auto_close;
          s_d.wr_bank   = c.bank;
          s_d.newest_wr = 1'b1;
        end else begin
          s_d.rd_live   = 1'b1;
          s_d.rd_age    = 8'h01;
          s_d.rd_len    = half;
          s_d.rd_ap     = c.auto_close;
          s_d.rd_bank   = c.bank;
          s_d.newest_wr = 1'b0;
        end
        s_d.stop_used = 1'b0;
      end
      CMD_STOP: begin
        if (s_q.stop_used) s_d.err = 1'b1;
        if (s_q.newest_wr) begin
          if (!s_q.wr_live || s_q.wr_age >= s_q.wr_len ||
              s_q.wr_age[0] || s_q.wr_ap)
            s_d.err = 1'b1;
          else begin
            s_d.wr_len = s_q.wr_age;
            // write recovery now counts from the stop
            s_d.bk_cnt[s_q.wr_bank] = WL + WR_CYC;
          end
        end else begin
          if (!s_q.rd_live || s_q.rd_age >= s_q.rd_len ||
              s_q.rd_age[0] || s_q.rd_ap)
            s_d.err = 1'b1;
          else begin
            s_d.rd_len = s_q.rd_age;
            s_d.bk_cnt[s_q.rd_bank] = '0;
          end
        end
        s_d.stop_used = 1'b1;
      end
      CMD_CLOSE: begin
        for (int b = 0; b < BANKS; b++) begin
          if (close_hit[b]) begin
            if (s_q.bk_st[b] == BANK_OPEN && s_q.bk_ras[b] < RAS_CYC)
              s_d.err = 1'b1;
            if (s_q.bk_st[b] == BANK_OPEN && s_q.bk_cnt[b] != '0)
              s_d.err = 1'b1;
            s_d.bk_st[b]  = BANK_CLOSING;
            s_d.bk_cnt[b] = (c.all_banks ? RPAB_CYC : RPPB_CYC) - 8'h01;
          end
        end
      end
      CMD_ACT: begin
        if (s_q.bk_st[c.bank] != BANK_IDLE) s_d.err = 1'b1;
        s_d.bk_st[c.bank]  = BANK_OPEN;
        // counts from one so a close at exactly the minimum passes
        s_d.bk_ras[c.bank] = 8'h01;
        s_d.bk_cnt[c.bank] = '0;
      end
      default: ;
    endcase
    // close guards hold one less than the spacing: the minimum is legal
    if (c.cmd == CMD_WRITE)
      s_d.bk_cnt[c.bank] = WL + half + WR_CYC;
    if (c.cmd == CMD_READ)
      s_d.bk_cnt[c.bank] = half + RTP_EFF - 8'h03;
    for (int b = 0; b < BANKS; b++) s_d.open[b] = s_d.bk_st[b] == BANK_OPEN;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bank_open   = s_q.open;
  assign array_wdata = s_q.wdata;
  assign array_we    = s_q.we;
  assign rd_beat     = s_q.rbeat;
  assign spacing_err = s_q.err;
endmodule : ddr_burst_tracker

// ### logic/ddr_cmd_pkg.sv
// constants and types for the burst-stop and bank-close command tracker
package ddr_cmd_pkg;
  localparam int BANKS        = 8;
  localparam int BANK_W       = 3;
  localparam int CNT_W        = 8;
  localparam int LANES        = 2;
  // command/address bit positions on the rising edge
  localparam int CA_B0        = 0;
  localparam int CA_B1        = 1;
  localparam int CA_B2        = 2;
  localparam int CA_B3        = 3;
  localparam int CA_ALLBANKS  = 4;
  localparam int CA_BANK_LSB  = 7;
  localparam int CA_W         = 10;
  // burst length encodings (beats)
  localparam logic [4:0] BL4  = 5'h04;
  localparam logic [4:0] BL8  = 5'h08;
  localparam logic [4:0] BL16 = 5'h10;
  // auto-close starts this many cycles after the last write beat
  localparam logic [CNT_W-1:0] WR_AUTO_LAG = 8'h02;
  // timing in ps, rounded up to whole 4 ns clocks; plain defaults
  localparam int CLK_PS       = 4000;
  localparam int T_WTR_PS     = 7500;
  localparam int T_WR_PS      = 15000;
  localparam int T_RTP_PS     = 7500;
  localparam int T_RPPB_PS    = 18000;
  localparam int T_RPAB_PS    = 21000;
  localparam int T_RAS_PS     = 42000;
  localparam logic [CNT_W-1:0] WTR_CYC  =
    CNT_W'((T_WTR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] WR_CYC   =
    CNT_W'((T_WR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] RTP_CYC  =
    CNT_W'((T_RTP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] RPPB_CYC =
    CNT_W'((T_RPPB_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] RPAB_CYC =
    CNT_W'((T_RPAB_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] RAS_CYC  =
    CNT_W'((T_RAS_PS + CLK_PS - 1) / CLK_PS);

  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_READ  = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_STOP  = 3'b011,
    CMD_CLOSE = 3'b100,
    CMD_ACT   = 3'b101
  } cmd_t;

  typedef enum logic [1:0] {
    BANK_IDLE    = 2'b00,
    BANK_OPEN    = 2'b01,
    BANK_CLOSING = 2'b10
  } bank_st_t;
endpackage : ddr_cmd_pkg

// ### logic/cmd_if.sv
// decoded command bundle between the decoder and the tracker
`timescale 1ns/1ps
interface cmd_if;
  import ddr_cmd_pkg::*;
  cmd_t                  cmd;
  logic                  auto_close;
  logic                  all_banks;
  logic [BANK_W-1:0]     bank;
  modport dec (output cmd, output auto_close, output all_banks,
               output bank);
  modport trk (input cmd, input auto_close, input all_banks, input bank);
endinterface : cmd_if

// ### logic/cmd_decode.sv
// command decoder for the rising-edge command/address word
`timescale 1ns/1ps
module cmd_decode
  import ddr_cmd_pkg::*;
(
  input  wire logic            cs_n,          // chip select, active low
  input  wire logic [CA_W-1:0] ca_rise,       // command bits, rising edge
  input  wire logic            auto_close_pin_falling, // flag, falling half
  cmd_if.dec                   dec             // decoded command
);
  always_comb begin
    dec.cmd        = CMD_NONE;
    dec.auto_close = 1'b0;
    dec.all_banks  = ca_rise[CA_ALLBANKS];
    dec.bank       = ca_rise[CA_BANK_LSB +: BANK_W];
    if (!cs_n) begin
      if (ca_rise[CA_B0] && !ca_rise[CA_B1]) begin
        dec.cmd        = ca_rise[CA_B2] ? CMD_READ : CMD_WRITE;
        dec.auto_close = auto_close_pin_falling;
      end else if (ca_rise[CA_B0] && ca_rise[CA_B1] && !ca_rise[CA_B2]) begin
        dec.cmd = ca_rise[CA_B3] ? CMD_CLOSE : CMD_STOP;
      end else if (!ca_rise[CA_B0] && ca_rise[CA_B1] && !ca_rise[CA_B2]) begin
        dec.cmd = CMD_ACT;
      end
      // refresh and mode-register codes are not tracked here
    end
  end
endmodule : cmd_decode

// ### testbench/ctrl_model.sv
// memory controller model driving the command pins
`timescale 1ns/1ps
module ctrl_model
  import ddr_cmd_pkg::*;
(
  input  wire logic            core_clk,              // clock
  output logic                 cs_n,                  // select, low
  output logic [CA_W-1:0]      ca_rise,               // command word
  output logic                 auto_close_pin_falling // auto-close
);
  initial begin
    cs_n = 1'b1;
    ca_rise = '0;
    auto_close_pin_falling = 1'b0;
  end
  // one command, taken at the next rising edge
  task automatic send(input cmd_t c, input logic [2:0] b, input logic ap,
                      input logic all);
    logic [3:0] op;
    case (c)
      CMD_ACT:   op = 4'h2;
      CMD_READ:  op = 4'h5;
      CMD_WRITE: op = 4'h1;
      CMD_STOP:  op = 4'h3;
      default:   op = 4'hb;
    endcase
    cs_n <= 1'b0;
    ca_rise <= {b, 2'b00, all, op};
    auto_close_pin_falling <= ap;
    @(posedge core_clk);
  endtask : send
  // deselected: bus shows no stale command
  task automatic idle(input int n);
    cs_n <= 1'b1;
    ca_rise <= ~ca_rise;
    auto_close_pin_falling <= ~auto_close_pin_falling;
    repeat (n) @(posedge core_clk);
  endtask : idle
endmodule : ctrl_model

// ### testbench/burst_chk_sva.sv
// port checker for the burst and bank-close tracker
`timescale 1ns/1ps
module burst_chk
  import ddr_cmd_pkg::*;
#(
  parameter int WL_CYC = 1,
  parameter int RL_CYC = 3,
  parameter int DQ_W   = 16
) (
  input wire logic              core_clk,    // clock
  input wire logic              rst,         // reset
  input wire logic              cs_n,        // select
  input wire logic [CA_W-1:0]   ca_rise,     // command
  input wire logic              auto_close_pin_falling, // flag
  input wire logic [4:0]        burst_beats, // length
  input wire logic [DQ_W-1:0]   wr_data,     // beat data
  input wire logic [DQ_W/8-1:0] byte_mask,   // lane mask
  input wire logic [DQ_W-1:0]   array_wdata, // array data
  input wire logic [DQ_W/8-1:0] array_we,    // lane enables
  input wire logic              rd_beat,     // read beat
  input wire logic [BANKS-1:0]  bank_open,   // open map
  input wire logic              spacing_err  // violation
);
  localparam int GAP4 = WL_CYC + 3 + int'(WTR_CYC);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic              is_wr, is_rd, is_stop, is_close, is_act, bl4_q;
  logic [3:0]        op;
  logic [BANK_W-1:0] bnk, ap_bank_q;
  logic [CNT_W-1:0]  age_q;
  assign op       = cs_n ? 4'h0 : ca_rise[3:0];
  assign bnk      = ca_rise[CA_BANK_LSB +: BANK_W];
  assign is_wr    = op[2:0] == 3'b001;
  assign is_rd    = op[2:0] == 3'b101;
  assign is_act   = op[2:0] == 3'b010;
  assign is_stop  = op == 4'h3;
  assign is_close = op == 4'hb;
  // age since the last write; bl4_q marks an unstopped four-beat write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      age_q <= '1;
      bl4_q <= 1'b0;
    end else if (is_wr) begin
      age_q <= 8'h01;
      bl4_q <= burst_beats == BL4;
    end else begin
      if (age_q != '1)
        age_q <= age_q + 8'h01;
      if (is_stop)
        bl4_q <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (is_wr && auto_close_pin_falling)
      ap_bank_q <= bnk;
  end
  sequence s_beat;
    array_we == ~$past(byte_mask);
  endsequence
  sequence s_wr16;
    is_wr && burst_beats == BL16 && !auto_close_pin_falling;
  endsequence
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> array_we == '0 && !rd_beat && bank_open == '0 && !spacing_err)
    else $error("outputs not cleared by reset");
  lane_mask_a: assert property (array_we != '0 |-> s_beat)
    else $error("lane enable ignores mask");
  wdata_pass_a: assert property (array_we != '0 |->
    array_wdata == $past(wr_data)) else $error("beat data not passed on");
  wr_len4_a: assert property (is_wr && burst_beats == BL4 |->
    ##2 s_beat ##1 s_beat) else $error("short write beats missing");
  stop_wr_a: assert property (s_wr16 ##2 is_stop ##1 !is_wr |->
    ##1 array_we == '0) else $error("stopped write kept writing");
  act_open_a: assert property (is_act |=> bank_open[$past(bnk)])
    else $error("activated bank not open");
  close_one_a: assert property (is_close && !ca_rise[CA_ALLBANKS] |=>
    bank_open == ($past(bank_open) & ~(8'h01 << $past(bnk))))
    else $error("single close hit wrong banks");
  close_all_a: assert property (is_close && ca_rise[CA_ALLBANKS] |=>
    bank_open == '0) else $error("close all left a bank open");
  auto_wr_a: assert property (is_wr && auto_close_pin_falling &&
    burst_beats == BL4 |=> bank_open[ap_bank_q] [*2] ##[1:20]
    !bank_open[ap_bank_q]) else $error("no auto-close after write");
  wr_rd_gap_a: assert property (is_rd && bl4_q && age_q < GAP4 |=>
    spacing_err) else $error("early read not flagged");
endmodule : burst_chk
bind ddr_burst_tracker burst_chk #(.WL_CYC(WL_CYC), .RL_CYC(RL_CYC),
  .DQ_W(DQ_W)) u_chk (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .ca_rise(ca_rise), .auto_close_pin_falling(auto_close_pin_falling),
  .burst_beats(burst_beats), .wr_data(wr_data), .byte_mask(byte_mask),
  .array_wdata(array_wdata), .array_we(array_we), .rd_beat(rd_beat),
  .bank_open(bank_open), .spacing_err(spacing_err));

// ### testbench/testbench.sv
// self-checking bench for the burst and bank-close tracker
`timescale 1ns/1ps
module testbench;
  import ddr_cmd_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst;
  logic             cs_n, auto_close_pin_falling, rd_beat, spacing_err;
  logic [CA_W-1:0]  ca_rise;
  logic [4:0]       burst_beats;
  logic [15:0]      wr_data;
  logic [1:0]       byte_mask;
  logic [15:0]      array_wdata;
  logic [1:0]       array_we;
  logic [BANKS-1:0] bank_open, exp_open;
  logic [15:0]      c0 = '0, c1 = '0, rc = '0, ec = '0, s0, s1, sr, se;
  int               err_total = 0;
  int               comparisons = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) wr_data <= wr_data + 16'h1357;
  // counters are only read after quiet spans, so no edge race
  always @(posedge core_clk) begin
    if (!rst) begin
      c0 <= c0 + 16'(array_we[0]);
      c1 <= c1 + 16'(array_we[1]);
      rc <= rc + 16'(rd_beat);
      ec <= ec + 16'(spacing_err);
    end
  end
  ddr_burst_tracker u_dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
    .ca_rise(ca_rise), .auto_close_pin_falling(auto_close_pin_falling),
    .burst_beats(burst_beats), .wr_data(wr_data), .byte_mask(byte_mask),
    .array_wdata(array_wdata), .array_we(array_we), .rd_beat(rd_beat),
    .bank_open(bank_open), .spacing_err(spacing_err));
  ctrl_model u_ctrl (.core_clk(core_clk), .cs_n(cs_n), .ca_rise(ca_rise),
    .auto_close_pin_falling(auto_close_pin_falling));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [2:0] b, input logic ap);
    u_ctrl.send(CMD_WRITE, b, ap, 1'b0);
  endtask : wr
  initial begin
    rst = 1'b1;
    burst_beats = BL4;
    wr_data = 16'h0000;
    byte_mask = 2'b00;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    u_ctrl.idle(2);
    chk({rd_beat, spacing_err, array_we, 4'h0, bank_open}, '0);
    for (int b = 0; b < BANKS; b++) begin
      u_ctrl.send(CMD_ACT, 3'(b), 1'b0, 1'b0);
      u_ctrl.idle(2);
    end
    u_ctrl.idle(12);
    chk(16'(bank_open), 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      burst_beats <= 5'(4 << i);
      u_ctrl.idle(2);
      {s1, se} = {c1, ec};
      wr(3'(i), 1'b0);
      u_ctrl.idle((2 << i) - 1);
      wr(3'(i + 3), 1'b0);
      u_ctrl.idle(30);
      chk(c1 - s1, 16'(4 << i));
      chk(ec - se, 16'h0000);
    end
    burst_beats <= BL8;
    u_ctrl.idle(2);
    s1 = c1;
    wr(3'd0, 1'b0);
    u_ctrl.idle(1);
    wr(3'd1, 1'b0);
    u_ctrl.idle(30);
    chk(c1 - s1, 16'h0006);
    burst_beats <= BL16;
    u_ctrl.idle(2);
    s1 = c1;
    wr(3'd2, 1'b0);
    u_ctrl.idle(1);
    u_ctrl.send(CMD_STOP, 3'd0, 1'b0, 1'b0);
    u_ctrl.idle(30);
    chk(c1 - s1, 16'h0002);
    burst_beats <= BL4;
    byte_mask <= 2'b01;
    u_ctrl.idle(2);
    {s0, s1, sr, se} = {c0, c1, rc, ec};
    wr(3'd5, 1'b0);
    u_ctrl.idle(1);
    u_ctrl.send(CMD_READ, 3'd5, 1'b0, 1'b0);
    u_ctrl.idle(30);
    chk(c0 - s0, 16'h0000);
    chk(c1 - s1, 16'h0002);
    chk(rc - sr, 16'h0002);
    chk(ec - se, 16'h0001);
    burst_beats <= BL16;
    {sr, se} = {rc, ec};
    u_ctrl.send(CMD_READ, 3'd4, 1'b0, 1'b0);
    u_ctrl.idle(1);
    u_ctrl.send(CMD_STOP, 3'd0, 1'b0, 1'b0);
    u_ctrl.send(CMD_STOP, 3'd0, 1'b0, 1'b0);
    u_ctrl.idle(30);
    chk(rc - sr, 16'h0002);
    chk(ec - se, 16'h0001);
    burst_beats <= BL4;
    byte_mask <= 2'b00;
    wr(3'd6, 1'b1);
    u_ctrl.idle(30);
    chk(16'(bank_open), 16'h00bf);
    exp_open = 8'hbf;
    for (int b = 0; b < BANKS; b++) begin
      u_ctrl.send(CMD_CLOSE, 3'(b), 1'b0, 1'b0);
      u_ctrl.idle(8);
      exp_open[b] = 1'b0;
      chk(16'(bank_open), 16'(exp_open));
    end
    u_ctrl.send(CMD_ACT, 3'd1, 1'b0, 1'b0);
    u_ctrl.idle(2);
    u_ctrl.send(CMD_ACT, 3'd3, 1'b0, 1'b0);
    u_ctrl.idle(16);
    u_ctrl.send(CMD_CLOSE, 3'd0, 1'b0, 1'b1);
    u_ctrl.idle(8);
    chk(16'(bank_open), 16'h0000);
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
endmodule : testbench
